// ==== verilog/pwl_ctrl.sv ====
// Top: PIR sensor input routing, light-pin sampling and white-light immunity
// Functional notes
// - Init automatically configures all sensing pins
// - One or two sensors, normal or low rate
// - Sensor one to converter, differential buffered
// - One sensor: reference on negative input
// - Smallest package ties reference internally
// - Two sensors: sensor two on negative input
// - Nonzero threshold schedules light-pin samples
// - Light pin analog for conversion, then output
// - Light step compensates sensor level shift
// - Sticky light flag until application clears
// - Anti-jam enable is control bit five
// - Twelve quick events start ignoring light
// - Quiet period resumes light handling
// - Tick set by application, cleared by service
`timescale 1ns/100ps
module pwl_ctrl
  import pwl_pkg::*;
#(
  parameter int unsigned AW         = ADC_W,
  parameter int unsigned TW         = WLT_W,
  parameter bit          SMALL_PKG  = 1'b0,
  parameter int unsigned NORM_CYC   = SCAN_NORM_CYC,
  parameter int unsigned LOW_CYC    = SCAN_LOW_CYC,
  parameter int unsigned JAM_EV     = JAM_EVENTS,
  parameter int unsigned JAM_WIN    = JAM_WIN_TICKS,
  parameter int unsigned JAM_QUIET  = JAM_QUIET_TICKS
) (
  input  wire logic          sys_clk,
  input  wire logic          srst,
  input  wire logic          engine_init_entry,
  input  wire logic          engine_enable,
  input  wire logic          dual_sensor_mode,
  input  wire logic          low_scan_rate,
  input  wire logic [TW-1:0] white_light_threshold,
  input  wire logic [7:0]    advanced_control_zero,
  input  wire logic [15:0]   system_clock_khz,
  input  wire logic          tick_set,
  input  wire logic          white_light_clear,
  input  wire logic          adc_done,
  input  wire logic [AW-1:0] adc_data,
  input  wire logic          light_pin_in,
  output      logic          adc_start,
  output      logic [1:0]    adc_pos_sel,
  output      logic [1:0]    adc_neg_sel,
  output      logic          adc_differential,
  output      logic          adc_buffered,
  output      logic          adc_vref_en,
  output      logic          vref_pin_out_en,
  output      logic          vref_to_neg_int,
  output      logic          sensor_one_analog,
  output      logic          sensor_two_or_ref_analog,
  output      logic          light_sense_analog,
  output      logic          light_sense_out,
  output      logic          light_sense_oe_n,
  output      logic          sensor_valid,
  output      logic [AW-1:0] sensor_sample,
  output      logic          light_comp_active,
  output      logic          white_light_detected,
  output      logic          jam_active,
  output      logic          tick_pending,
  output      logic [15:0]   clock_khz_latched
);
  pwl_state_t              state_r;
  logic                    configured_r;
  logic [SCAN_CNT_W-1:0]   scan_r;
  logic [SET_CNT_W-1:0]    settle_r;
  logic [AW-1:0]           light_prev_r;
  logic                    light_prev_ok_r;
  logic                    light_led_r;
  logic                    light_pin_s;
  logic                    wl_en;
  logic                    anti_jam_en;
  logic                    light_step;
  logic                    jammed;
  logic [AW:0]             light_diff;
  logic                    conv_service;

  initial begin
    if (AW < 2 || AW > 16 || TW < 1 || TW > AW)
      $error("pwl_ctrl: width parameter out of range");
    if (NORM_CYC < 1 || LOW_CYC < 1 || LOW_CYC >= (1 << SCAN_CNT_W) ||
        NORM_CYC >= (1 << SCAN_CNT_W))
      $error("pwl_ctrl: scan interval out of range");
  end

  assign wl_en        = (white_light_threshold != '0);
  assign anti_jam_en  = advanced_control_zero[ANTI_JAM_BIT];
  assign conv_service = adc_done && (state_r == PWL_SENS_WAIT);

  // Read-back of the pin level, registered and driven back out on light_sense_out
  pwl_sync #(
    .WIDTH (1)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       (light_pin_in),
    .q       (light_pin_s)
  );

  always_ff @(posedge sys_clk) begin
    if (srst)
      light_led_r <= 1'b0;
    else
      light_led_r <= light_pin_s;
  end

  // Pin roles and converter mode taken on init
  always_ff @(posedge sys_clk) begin
    if (srst || !engine_enable) begin
      configured_r             <= 1'b0;
      adc_differential         <= 1'b0;
      adc_buffered             <= 1'b0;
      adc_vref_en              <= 1'b0;
      vref_pin_out_en          <= 1'b0;
      vref_to_neg_int          <= 1'b0;
      sensor_one_analog        <= 1'b0;
      sensor_two_or_ref_analog <= 1'b0;
      adc_pos_sel              <= CH_NONE;
      clock_khz_latched        <= '0;
    end else if (engine_init_entry) begin
      configured_r             <= 1'b1;
      clock_khz_latched        <= system_clock_khz;
      sensor_one_analog        <= 1'b1;
      sensor_two_or_ref_analog <= 1'b1;
      adc_pos_sel              <= CH_SENS_ONE;
      adc_differential         <= 1'b1;
      adc_buffered             <= 1'b1;
      adc_vref_en              <= 1'b1;
      vref_pin_out_en          <= !dual_sensor_mode && !SMALL_PKG;
      vref_to_neg_int          <= !dual_sensor_mode && SMALL_PKG;
    end else if (state_r == PWL_LIGHT_START) begin
      adc_pos_sel      <= CH_LIGHT;
      adc_differential <= 1'b0;
    end else if (state_r == PWL_IDLE) begin
      adc_pos_sel      <= configured_r ? CH_SENS_ONE : CH_NONE;
      adc_differential <= configured_r;
    end
  end

  // Negative input set to sensor two on init, whatever the sensor count
  always_ff @(posedge sys_clk) begin
    if (srst || !engine_enable)
      adc_neg_sel <= CH_NONE;
    else if (engine_init_entry)
      adc_neg_sel <= CH_SENS_TWO;
  end

  // Scan interval timer, normal or low rate
  always_ff @(posedge sys_clk) begin
    if (srst || !configured_r)
      scan_r <= '0;
    else if (scan_r == '0 && state_r == PWL_IDLE)
      scan_r <= low_scan_rate ? SCAN_CNT_W'(LOW_CYC - 1)
                              : SCAN_CNT_W'(NORM_CYC - 1);
    else if (scan_r != '0)
      scan_r <= scan_r - 1'b1;
  end

  // Conversion sequencer
  always_ff @(posedge sys_clk) begin
    if (srst || !engine_enable || !configured_r) begin
      state_r   <= PWL_IDLE;
      adc_start <= 1'b0;
      settle_r  <= '0;
    end else begin
      adc_start <= 1'b0;
      case (state_r)
        PWL_IDLE: begin
          if (scan_r == '0) begin
            state_r <= PWL_SENS_START;
          end
        end
        PWL_SENS_START: begin
          adc_start <= 1'b1;
          state_r   <= PWL_SENS_WAIT;
        end
        PWL_SENS_WAIT: begin
          if (adc_done) begin
            if (wl_en) begin
              state_r  <= PWL_LIGHT_SETUP;
              settle_r <= SET_CNT_W'(SETTLE_CYC);
            end else begin
              state_r <= PWL_IDLE;
            end
          end
        end
        PWL_LIGHT_SETUP: begin
          if (settle_r == '0)
            state_r <= PWL_LIGHT_START;
          else
            settle_r <= settle_r - 1'b1;
        end
        PWL_LIGHT_START: begin
          adc_start <= 1'b1;
          state_r   <= PWL_LIGHT_WAIT;
        end
        PWL_LIGHT_WAIT: begin
          if (adc_done)
            state_r <= PWL_IDLE;
        end
        default: begin
          state_r <= PWL_IDLE;
        end
      endcase
    end
  end

  // Light pin: digital output once configured, except while sampled
  always_ff @(posedge sys_clk) begin
    if (srst || !configured_r) begin
      light_sense_analog <= 1'b0;
      light_sense_oe_n   <= 1'b1;
      light_sense_out    <= 1'b0;
    end else if (state_r == PWL_LIGHT_SETUP || state_r == PWL_LIGHT_START ||
                 (state_r == PWL_LIGHT_WAIT && !adc_done)) begin
      light_sense_analog <= 1'b1;
      light_sense_oe_n   <= 1'b1;
    end else begin
      light_sense_analog <= 1'b0;
      light_sense_oe_n   <= 1'b0;
      light_sense_out    <= light_led_r;
    end
  end

  // Light step detection against previous sample
  assign light_diff = {1'b0, adc_data} - {1'b0, light_prev_r};
  assign light_step = (state_r == PWL_LIGHT_WAIT) && adc_done && light_prev_ok_r &&
                      !light_diff[AW] &&
                      (light_diff[AW-1:0] > AW'(white_light_threshold));

  always_ff @(posedge sys_clk) begin
    if (srst || !configured_r || !wl_en) begin
      light_prev_r    <= '0;
      light_prev_ok_r <= 1'b0;
    end else if (state_r == PWL_LIGHT_WAIT && adc_done) begin
      light_prev_r    <= adc_data;
      light_prev_ok_r <= 1'b1;
    end
  end

  pwl_jam #(
    .EVENTS (JAM_EV),
    .WIN    (JAM_WIN),
    .QUIET  (JAM_QUIET)
  ) u_jam (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .enable   (anti_jam_en && wl_en),
    .tick     (tick_pending && conv_service),
    .event_in (light_step),
    .jammed   (jammed)
  );

  // Compensation window, ends at next tick; ignored while jammed
  always_ff @(posedge sys_clk) begin
    if (srst || !wl_en || jammed)
      light_comp_active <= 1'b0;
    else if (light_step)
      light_comp_active <= 1'b1;
    else if (tick_pending && conv_service)
      light_comp_active <= 1'b0;
  end

  // Sticky flag: set wins over clear
  always_ff @(posedge sys_clk) begin
    if (srst)
      white_light_detected <= 1'b0;
    else if (light_step && !jammed)
      white_light_detected <= 1'b1;
    else if (white_light_clear)
      white_light_detected <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (srst)
      jam_active <= 1'b0;
    else
      jam_active <= jammed;
  end

  // Housekeeping tick: set wins over clear
  always_ff @(posedge sys_clk) begin
    if (srst)
      tick_pending <= 1'b0;
    else if (tick_set)
      tick_pending <= 1'b1;
    else if (conv_service)
      tick_pending <= 1'b0;
  end

  // Sensor result capture
  always_ff @(posedge sys_clk) begin
    if (srst || !configured_r) begin
      sensor_valid  <= 1'b0;
      sensor_sample <= '0;
    end else begin
      sensor_valid <= conv_service;
      if (conv_service)
        sensor_sample <= adc_data;
    end
  end
endmodule : pwl_ctrl

// ==== verilog/pwl_pkg.sv ====
// Package: constants and types for the PIR input and white-light control block
package pwl_pkg;
  localparam int unsigned ADC_W          = 10;
  localparam int unsigned WLT_W          = 8;
  localparam int unsigned JAM_EVENTS     = 12;
  localparam int unsigned JAM_WIN_TICKS  = 4;
  localparam int unsigned JAM_QUIET_TICKS = 10;
  localparam int unsigned JAM_CNT_W      = 4;
  localparam int unsigned TICK_CNT_W     = 8;
  localparam int unsigned ANTI_JAM_BIT   = 5;
  localparam int unsigned TICK_BIT       = 7;
  localparam int unsigned SETTLE_NS      = 40;
  localparam int unsigned CLK_NS         = 4;
  localparam int unsigned SETTLE_CYC     = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SET_CNT_W      = 8;
  localparam int unsigned SCAN_NORM_CYC  = 250;
  localparam int unsigned SCAN_LOW_CYC   = 1000;
  localparam int unsigned SCAN_CNT_W     = 12;
  // Converter channel selects
  localparam logic [1:0]  CH_LIGHT       = 2'h1;
  localparam logic [1:0]  CH_SENS_ONE    = 2'h2;
  localparam logic [1:0]  CH_SENS_TWO    = 2'h3;
  localparam logic [1:0]  CH_NONE        = 2'h0;

  typedef enum logic [2:0] {
    PWL_IDLE,
    PWL_SENS_START,
    PWL_SENS_WAIT,
    PWL_LIGHT_SETUP,
    PWL_LIGHT_START,
    PWL_LIGHT_WAIT
  } pwl_state_t;
endpackage : pwl_pkg

// ==== verilog/pwl_sync.sv ====
// Two-flop synchroniser for a pin-level input
`timescale 1ns/100ps
module pwl_sync
  import pwl_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] d,
  output      logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : pwl_sync

// ==== verilog/pwl_jam.sv ====
// Anti-jam event counter with window and quiet period in housekeeping ticks
`timescale 1ns/100ps
module pwl_jam
  import pwl_pkg::*;
#(
  parameter int unsigned EVENTS  = JAM_EVENTS,
  parameter int unsigned WIN     = JAM_WIN_TICKS,
  parameter int unsigned QUIET   = JAM_QUIET_TICKS
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic enable,
  input  wire logic tick,
  input  wire logic event_in,
  output      logic jammed
);
  logic [JAM_CNT_W-1:0]  ev_cnt_r;
  logic [TICK_CNT_W-1:0] win_r;
  logic [TICK_CNT_W-1:0] quiet_r;

  initial begin
    if (EVENTS < 1 || EVENTS >= (1 << JAM_CNT_W) || WIN < 1 || QUIET < 1 ||
        WIN >= (1 << TICK_CNT_W) || QUIET >= (1 << TICK_CNT_W))
      $error("pwl_jam: parameter out of range");
  end

  // Events counted inside a window; window restarts on first event
  always_ff @(posedge sys_clk) begin
    if (srst || !enable) begin
      ev_cnt_r <= '0;
      win_r    <= '0;
    end else if (jammed) begin
      ev_cnt_r <= '0;
      win_r    <= '0;
    end else if (event_in) begin
      ev_cnt_r <= ev_cnt_r + 1'b1;
      if (ev_cnt_r == '0)
        win_r <= TICK_CNT_W'(WIN);
    end else if (tick && win_r != '0) begin
      win_r <= win_r - 1'b1;
      if (win_r == 1)
        ev_cnt_r <= '0;
    end
  end

  // Suppression held until a quiet span passes without events
  always_ff @(posedge sys_clk) begin
    if (srst || !enable) begin
      jammed  <= 1'b0;
      quiet_r <= '0;
    end else if (!jammed) begin
      if (event_in && ev_cnt_r == JAM_CNT_W'(EVENTS - 1)) begin
        jammed  <= 1'b1;
        quiet_r <= TICK_CNT_W'(QUIET);
      end
    end else if (event_in) begin
      quiet_r <= TICK_CNT_W'(QUIET);
    end else if (tick) begin
      if (quiet_r == 1)
        jammed <= 1'b0;
      quiet_r <= quiet_r - 1'b1;
    end
  end
endmodule : pwl_jam

// ==== verification/pwl_adc_model.sv ====
// Converter and light-pin model facing the PIR control block
`timescale 1ns/100ps
module pwl_adc_model
  import pwl_pkg::*;
#(
  parameter int unsigned LAT = 5
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic             adc_start,
  input  wire logic [1:0]       adc_pos_sel,
  input  wire logic             light_sense_out,
  input  wire logic             light_sense_oe_n,
  input  wire logic [ADC_W-1:0] sens_lvl,
  input  wire logic [ADC_W-1:0] light_lvl,
  output      logic             adc_done,
  output      logic [ADC_W-1:0] adc_data,
  output      logic             light_pin_in
);
  int unsigned cnt_r;
  logic [1:0]  ch_r;
  initial begin
    adc_done = 1'b0;
    adc_data = '0;
    cnt_r = 0;
  end
  // Released pin falls to the pull-down
  assign light_pin_in = light_sense_oe_n ? 1'b0 : light_sense_out;
  always @(posedge sys_clk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (srst) begin
      cnt_r <= 0;
    end else if (adc_start) begin
      cnt_r <= LAT;
      ch_r  <= adc_pos_sel;
    end else if (cnt_r == 1) begin
      cnt_r    <= 0;
      adc_done <= 1'b1;
      adc_data <= (ch_r == CH_LIGHT) ? light_lvl : sens_lvl;
    end else if (cnt_r != 0) begin
      cnt_r <= cnt_r - 1;
    end
  end
endmodule : pwl_adc_model

// ==== verification/pwl_ctrl_chk.sv ====
// Assertion checker for the PIR input and white-light control block
`timescale 1ns/100ps
module pwl_ctrl_chk
  import pwl_pkg::*;
#(
  parameter bit SMALL_PKG = 1'b0
) (
  input wire logic             sys_clk,
  input wire logic             srst,
  input wire logic             engine_init_entry,
  input wire logic             engine_enable,
  input wire logic             dual_sensor_mode,
  input wire logic [WLT_W-1:0] white_light_threshold,
  input wire logic [15:0]      system_clock_khz,
  input wire logic             tick_set,
  input wire logic             white_light_clear,
  input wire logic             adc_done,
  input wire logic [ADC_W-1:0] adc_data,
  input wire logic             adc_start,
  input wire logic [1:0]       adc_pos_sel,
  input wire logic [1:0]       adc_neg_sel,
  input wire logic             adc_differential,
  input wire logic             adc_buffered,
  input wire logic             adc_vref_en,
  input wire logic             vref_pin_out_en,
  input wire logic             vref_to_neg_int,
  input wire logic             sensor_one_analog,
  input wire logic             sensor_two_or_ref_analog,
  input wire logic             light_sense_analog,
  input wire logic             light_sense_oe_n,
  input wire logic             sensor_valid,
  input wire logic [ADC_W-1:0] sensor_sample,
  input wire logic             white_light_detected,
  input wire logic             tick_pending,
  input wire logic [15:0]      clock_khz_latched
);
  logic go;
  assign go = engine_enable && engine_init_entry;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  AST_INIT_CFG: assert property (
    go |=> adc_pos_sel == CH_SENS_ONE && adc_differential && adc_buffered && sensor_one_analog)
    else $error("init config missing");
  AST_NEG_SEL: assert property (
    go |=> adc_neg_sel == CH_SENS_TWO && sensor_two_or_ref_analog)
    else $error("negative input wrong");
  AST_VREF: assert property (
    go |=> adc_vref_en && vref_pin_out_en == (!$past(dual_sensor_mode) && !SMALL_PKG)
           && vref_to_neg_int == (!$past(dual_sensor_mode) && SMALL_PKG))
    else $error("reference routing wrong");
  AST_LIGHT_PIN: assert property (
    light_sense_analog |-> light_sense_oe_n)
    else $error("light pin driven while sampled");
  AST_LIGHT_CONV: assert property (
    disable iff (srst || !engine_enable)
    $rose(light_sense_analog) |-> ##[8:14] (adc_start && adc_pos_sel == CH_LIGHT
                                            && !adc_differential))
    else $error("light conversion not started");
  AST_ZERO_THR: assert property (
    white_light_threshold == '0 |-> !light_sense_analog)
    else $error("light sampled with zero threshold");
  AST_FLAG_HOLD: assert property (
    white_light_detected && !white_light_clear && engine_enable |=> white_light_detected)
    else $error("light flag lost");
  AST_FLAG_CAUSE: assert property (
    $rose(white_light_detected) |-> $past(light_sense_analog) || $past(light_sense_analog, 2))
    else $error("light flag without light sample");
  AST_SENS_VALID: assert property (
    adc_done && engine_enable && !light_sense_analog && adc_pos_sel == CH_SENS_ONE
    |=> sensor_valid && sensor_sample == $past(adc_data))
    else $error("sensor result not delivered");
  AST_TICK: assert property (
    tick_set && !adc_done |=> tick_pending)
    else $error("tick not pending");
  AST_KHZ: assert property (
    go |=> clock_khz_latched == $past(system_clock_khz))
    else $error("clock value not latched");
  AST_OFF: assert property (
    !engine_enable |=> !adc_differential && !sensor_one_analog && !adc_start)
    else $error("config kept while disabled");
  COV_DUAL: cover property (go && dual_sensor_mode);
  COV_FLAG: cover property ($rose(white_light_detected));
  COV_TICK: cover property (tick_pending ##1 !tick_pending);
endmodule : pwl_ctrl_chk

bind pwl_ctrl pwl_ctrl_chk #(.SMALL_PKG(SMALL_PKG)) u_chk (
  .sys_clk, .srst, .engine_init_entry, .engine_enable, .dual_sensor_mode,
  .white_light_threshold, .system_clock_khz, .tick_set, .white_light_clear, .adc_done,
  .adc_data, .adc_start, .adc_pos_sel, .adc_neg_sel, .adc_differential, .adc_buffered,
  .adc_vref_en, .vref_pin_out_en, .vref_to_neg_int, .sensor_one_analog,
  .sensor_two_or_ref_analog, .light_sense_analog, .light_sense_oe_n, .sensor_valid,
  .sensor_sample, .white_light_detected, .tick_pending, .clock_khz_latched);

// ==== verification/test_pwl_ctrl.sv ====
// Self-checking testbench for the PIR input and white-light control block
`timescale 1ns/100ps
module test_pwl_ctrl;
  import pwl_pkg::*;
  logic        sys_clk = 1'b0, srst = 1'b1, engine_init_entry = 1'b0, engine_enable = 1'b0;
  logic        dual_sensor_mode = 1'b0, low_scan_rate = 1'b0, tick_set = 1'b0;
  logic        white_light_clear = 1'b0, adc_done, light_pin_in, adc_start;
  logic [7:0]  white_light_threshold = 8'h00, advanced_control_zero = 8'h00;
  logic [15:0] system_clock_khz = 16'h0fa0, clock_khz_latched;
  logic [9:0]  adc_data, sensor_sample, sens_lvl = 10'h155, light_lvl = 10'h020;
  logic [1:0]  adc_pos_sel, adc_neg_sel;
  logic        adc_differential, adc_buffered, adc_vref_en, vref_pin_out_en, vref_to_neg_int;
  logic        sensor_one_analog, sensor_two_or_ref_analog, light_sense_analog;
  logic        light_sense_out, light_sense_oe_n, sensor_valid, light_comp_active;
  logic        white_light_detected, jam_active, tick_pending;
  int          n_mismatch = 0, compares = 0, g0, g1, k;
  logic [9:0]  lv [4] = '{10'h020, 10'h020, 10'h030, 10'h041};
  logic        ex [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

  always #2 sys_clk = ~sys_clk;

  pwl_ctrl #(.NORM_CYC(10), .LOW_CYC(20)) DUT (
    .sys_clk, .srst, .engine_init_entry, .engine_enable, .dual_sensor_mode, .low_scan_rate,
    .white_light_threshold, .advanced_control_zero, .system_clock_khz, .tick_set,
    .white_light_clear, .adc_done, .adc_data, .light_pin_in, .adc_start, .adc_pos_sel,
    .adc_neg_sel, .adc_differential, .adc_buffered, .adc_vref_en, .vref_pin_out_en,
    .vref_to_neg_int, .sensor_one_analog, .sensor_two_or_ref_analog, .light_sense_analog,
    .light_sense_out, .light_sense_oe_n, .sensor_valid, .sensor_sample, .light_comp_active,
    .white_light_detected, .jam_active, .tick_pending, .clock_khz_latched);

  pwl_adc_model u_adc (
    .sys_clk, .srst, .adc_start, .adc_pos_sel, .light_sense_out, .light_sense_oe_n,
    .sens_lvl, .light_lvl, .adc_done, .adc_data, .light_pin_in);

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic stuck(input string nm);
    n_mismatch++;
    $display("unexpected wait for %s: expected end seen none", nm);
    report_and_stop();
  endtask : stuck

  task automatic wait_sens;
    for (int i = 0; i < 3000; i++) begin
      @(posedge sys_clk);
      if (sensor_valid === 1'b1) return;
    end
    stuck("sensor result");
  endtask : wait_sens

  task automatic wait_light;
    for (int i = 0; i < 3000; i++) begin
      @(posedge sys_clk);
      if (adc_done === 1'b1 && adc_pos_sel === CH_LIGHT) return;
    end
    stuck("light conversion");
  endtask : wait_light

  task automatic gap(output int g);
    wait_sens();
    g = 0;
    do begin
      @(posedge sys_clk);
      g++;
    end while (sensor_valid !== 1'b1 && g < 5000);
    if (g >= 5000) stuck("scan gap");
  endtask : gap

  task automatic flash;
    light_lvl <= 10'h020;
    wait_light();
    light_lvl <= 10'h200;
    wait_light();
    repeat (3) @(posedge sys_clk);
  endtask : flash

  task automatic do_tick;
    int i;
    wait_sens();
    tick_set <= 1'b1;
    @(posedge sys_clk);
    tick_set <= 1'b0;
    @(posedge sys_clk);
    chk("tick_pending", 1'b1, tick_pending);
    for (i = 0; i < 3000 && tick_pending !== 1'b0; i++) @(posedge sys_clk);
    if (i >= 3000) stuck("tick service");
  endtask : do_tick

  task automatic start(input logic d, input logic l, input logic [7:0] thr);
    engine_enable <= 1'b0;
    repeat (8) @(posedge sys_clk);
    dual_sensor_mode <= d;
    low_scan_rate <= l;
    white_light_threshold <= thr;
    engine_enable <= 1'b1;
    @(posedge sys_clk);
    engine_init_entry <= 1'b1;
    @(posedge sys_clk);
    engine_init_entry <= 1'b0;
    @(posedge sys_clk);
    chk("pos_sel", CH_SENS_ONE, adc_pos_sel);
    chk("neg_sel", CH_SENS_TWO, adc_neg_sel);
    chk("diff_buf", 2'h3, {adc_differential, adc_buffered});
    chk("vref", {1'b1, ~d, 1'b0}, {adc_vref_en, vref_pin_out_en, vref_to_neg_int});
    chk("analog", 2'h3, {sensor_one_analog, sensor_two_or_ref_analog});
    chk("khz", system_clock_khz, clock_khz_latched);
  endtask : start

  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    start(1'b0, 1'b0, 8'h00);
    gap(g0);
    chk("sample", sens_lvl, sensor_sample);
    start(1'b0, 1'b1, 8'h00);
    gap(g1);
    chk("scan_gap", 16'h000a, 16'(g1 - g0));
    chk("flag_off", 1'b0, white_light_detected);
    start(1'b1, 1'b0, 8'h10);
    for (k = 0; k < 4; k++) begin
      light_lvl <= lv[k];
      wait_light();
      repeat (3) @(posedge sys_clk);
      chk("light_flag", ex[k], white_light_detected);
    end
    chk("comp_on", 1'b1, light_comp_active);
    repeat (60) @(posedge sys_clk);
    chk("flag_held", 1'b1, white_light_detected);
    white_light_clear <= 1'b1;
    @(posedge sys_clk);
    white_light_clear <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("flag_clr", 1'b0, white_light_detected);
    advanced_control_zero <= 8'h20;
    repeat (5) do_tick();
    chk("comp_end", 1'b0, light_comp_active);
    for (k = 0; k < 12; k++) begin
      chk("jam_early", 1'b0, jam_active);
      flash();
    end
    chk("jam_on", 1'b1, jam_active);
    white_light_clear <= 1'b1;
    @(posedge sys_clk);
    white_light_clear <= 1'b0;
    flash();
    chk("jam_ignored", 1'b0, white_light_detected);
    repeat (8) do_tick();
    chk("jam_quiet", 1'b1, jam_active);
    repeat (3) do_tick();
    chk("jam_off", 1'b0, jam_active);
    flash();
    chk("resumed", 1'b1, white_light_detected);
    engine_enable <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("off", 2'h1, {adc_differential, light_sense_oe_n});
    report_and_stop();
  end
endmodule : test_pwl_ctrl
